// ==== hsmfp_pkg.sv ====
// package: field layout, widths and types for the hex and secure message field parser
package hsmfp_pkg;
    localparam int CW_W        = 21;
    localparam int CHR_W       = 16;
    localparam int CNT_W       = 5;
    localparam int N_W         = 6;
    localparam int F_W         = 2;
    localparam int B_W         = 4;
    localparam int SIG_W       = 8;
    localparam int HEX_K_W     = 12;
    localparam int SEC_K_W     = 10;
    localparam int HEX_C_POS   = 12;
    localparam int HEX_F_LSB   = 13;
    localparam int HEX_N_LSB   = 15;
    localparam int SEC_C_POS   = 10;
    localparam int SEC_F_LSB   = 11;
    localparam int SEC_N_LSB   = 13;
    localparam int R_POS       = 0;
    localparam int M_POS       = 1;
    localparam int D_POS       = 2;
    localparam int H_POS       = 3;
    localparam int B_LSB       = 4;
    localparam int RSV_LSB     = 8;
    localparam int RSV_W       = 5;
    localparam int HEX_S_LSB   = 13;
    localparam int SEC_S_LSB   = 0;
    localparam int SEC_SIG_W   = 7;
    localparam logic [CNT_W-1:0] SEC_DATA_LSB = 5'h07;
    localparam logic [CNT_W-1:0] CW_BITS      = 5'h15;
    localparam logic [CNT_W-1:0] SEC_CHR_BITS = 5'h07;
    localparam logic [CNT_W-1:0] MAX_CHR_BITS = 5'h10;
    localparam logic [3:0]       HEX_GRP_BITS = 4'h8;
    localparam logic [3:0]       SEC_GRP_BITS = 4'h7;
    localparam logic [B_W-1:0]   B_TRANSPARENT = 4'h1;
    localparam logic [B_W-1:0]   B_SIXTEEN     = 4'h0;
    localparam logic [RSV_W-1:0] RSV_DEFAULT   = 5'h00;
    localparam logic [F_W-1:0]   F_LAST        = 2'h2;
    localparam logic [SIG_W-1:0] HEX_SIG_MASK  = 8'hFF;
    localparam logic [SIG_W-1:0] SEC_SIG_MASK  = 8'h7F;
    localparam logic [1:0]       W_FIRST       = 2'h0;
    localparam logic [1:0]       W_SECOND      = 2'h1;
    localparam logic [1:0]       W_DATA        = 2'h2;

    typedef enum logic [0:0] {
        HSMFP_IDLE  = 1'b0,
        HSMFP_SHIFT = 1'b1
    } hsmfp_phase_type;
endpackage

// ==== hsmfp_stream_if.sv ====
// interface: one valid/ready character stream between parser and buffer
`timescale 1ns/1ps
interface hsmfp_stream_if;
    logic                         valid;
    logic                         ready;
    logic [hsmfp_pkg::CHR_W-1:0]  data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ==== hsmfp_buffer.sv ====
// two-entry character buffer so a stalled receiver loses no character
`timescale 1ns/1ps
module hsmfp_buffer (
    input  wire logic  sys_clk,
    input  wire logic  rst_b,
    hsmfp_stream_if.snk push,
    hsmfp_stream_if.src pop
);
    import hsmfp_pkg::*;

    typedef struct packed {
        logic             o_valid;
        logic [CHR_W-1:0] o_data;
        logic             s_valid;
        logic [CHR_W-1:0] s_data;
    } hsmfp_buf_type;

    hsmfp_buf_type buf_reg;
    hsmfp_buf_type buf_next;
    logic          take;
    logic          give;

    assign take = push.valid && !buf_reg.s_valid;
    assign give = buf_reg.o_valid && pop.ready;

    always_comb
    begin
        buf_next = buf_reg;
        if (!buf_reg.o_valid || give)
        begin
            if (buf_reg.s_valid)
            begin
                buf_next.o_valid = 1'b1;
                buf_next.o_data  = buf_reg.s_data;
                buf_next.s_valid = take;
                buf_next.s_data  = push.data;
            end
            else
            begin
                buf_next.o_valid = take;
                buf_next.o_data  = push.data;
            end
        end
        else if (take)
        begin
            buf_next.s_valid = 1'b1;
            buf_next.s_data  = push.data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            buf_reg <= '0;
        else
            buf_reg <= buf_next;
    end

    // ready is the skid slot being empty, so it comes from a flop
    assign push.ready = !buf_reg.s_valid;
    assign pop.valid  = buf_reg.o_valid;
    assign pop.data   = buf_reg.o_data;

    a_buf_no_loss: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (pop.valid && !pop.ready) |=> (pop.valid && pop.data == $past(pop.data)))
        else $error("buffer output changed while stalled");
endmodule

// ==== hsmfp_parser.sv ====
// parser for hex/binary and secure message fields, fill termination and signature
// Behaviour
// [RULE1] data characters are 1 to 16 bits wide, width from blocking length
// [RULE2] fragment ends at last complete character; partial character is dropped
// [RULE3] fill after last data bit is its inverse; end found by that inversion
// [RULE4] an all-fill extra codeword after an exactly full final codeword marks end
// [RULE5] checksum, continuation, fragment and message number form each fragment's first word
// [RULE6] hex fragments carry a 12-bit checksum in the first word
// [RULE7] continuation flag set means more fragments follow in later frames
// [RULE8] 2-bit fragment number steps by one modulo 3; sequence is checked
// [RULE9] header flag marks a displayable header sharing the data message number
// [RULE10] control fields come only from second codeword of the first fragment
// [RULE11] retrieval flag set means the message must be numbered
// [RULE12] 5-bit reserved field, default 00000, is skipped; the code reads its top bit to gate msg_done when the control word is last
// [RULE13] mail-drop flag routes message to a dedicated overwritten store
// [RULE14] direction bit: 0 left-to-right, 1 right-to-left, only if length not 0001
// [RULE15] blocking length 0001 is 1 bit, 1111 is 15, 0000 is 16 bits
// [RULE16] signature is inverted low byte of 8-bit group sum, fill excluded
// [RULE17] sum starts after signature field; earlier bits sit in low positions
// [RULE18] secure messages carry 7-bit characters after the control fields
// [RULE19] secure messages use the same fragmentation and termination handling
// [RULE20] secure fragments carry a 10-bit checksum in the first word
// [RULE21] after final fragment computed and received signatures are compared
`timescale 1ns/1ps
module hsmfp_parser (
    input  wire logic                        sys_clk,
    input  wire logic                        rst_b,
    input  wire logic                        mode_secure,
    input  wire logic                        cw_valid,
    input  wire logic [hsmfp_pkg::CW_W-1:0]  cw_data,
    input  wire logic                        cw_first,
    input  wire logic                        cw_last,
    output logic                             cw_ready,
    output logic                             chr_valid,
    output logic [hsmfp_pkg::CHR_W-1:0]      chr_data,
    input  wire logic                        chr_ready,
    output logic [hsmfp_pkg::HEX_K_W-1:0]    frag_cksum,
    output logic                             expect_more,
    output logic [hsmfp_pkg::F_W-1:0]        frag_num,
    output logic [hsmfp_pkg::N_W-1:0]        msg_num,
    output logic                             hdr_msg,
    output logic                             retrieve_num,
    output logic                             mail_drop,
    output logic                             dir_rtl,
    output logic                             char_mode,
    output logic [hsmfp_pkg::CNT_W-1:0]      chr_bits,
    output logic [hsmfp_pkg::SIG_W-1:0]      sig_rx,
    output logic                             msg_done,
    output logic                             sig_mismatch,
    output logic                             frag_seq_err
);
    import hsmfp_pkg::*;

    typedef struct packed {
        hsmfp_phase_type   phase;
        logic              rdy;
        logic [CW_W-1:0]   cw;
        logic              last;
        logic [CNT_W-1:0]  lim;
        logic [CNT_W-1:0]  bitpos;
        logic [1:0]        widx;
        logic              sec;
        logic              first_frag;
        logic [CHR_W-1:0]  acc;
        logic [CNT_W-1:0]  acnt;
        logic              pend;
        logic [CHR_W-1:0]  chr;
        logic [SIG_W-1:0]  grp;
        logic [3:0]        gcnt;
        logic [SIG_W-1:0]  sum;
        logic [HEX_K_W-1:0] cksum;
        logic              cont;
        logic [F_W-1:0]    frag;
        logic [N_W-1:0]    num;
        logic              hdr;
        logic              retr;
        logic              mail;
        logic              dir;
        logic              cmode;
        logic [B_W-1:0]    blk;
        logic [SIG_W-1:0]  sig;
        logic              done;
        logic              mism;
        logic              seq_err;
        logic [CNT_W-1:0]  cbits;
    } hsmfp_state_type;

    hsmfp_state_type st_reg;
    hsmfp_state_type st_next;
    hsmfp_stream_if  push_if ();
    hsmfp_stream_if  out_if ();

    // number of data bits ahead of the trailing fill run; 0 for an all-fill word
    function automatic logic [CNT_W-1:0] fill_limit(input logic [CW_W-1:0] w);
        logic [CNT_W-1:0] n;
        n = '0;
        for (int i = 0; i < CW_W; i++)
            if (w[i] != w[CW_W-1])
                n = CNT_W'(i + 1);
        return n;
    endfunction

    function automatic logic [CNT_W-1:0] chr_width(input logic sec, input logic [B_W-1:0] blk);
        if (sec)
            return SEC_CHR_BITS;
        else if (blk == B_SIXTEEN)
            return MAX_CHR_BITS;
        else
            return {1'b0, blk};
    endfunction

    function automatic logic [F_W-1:0] frag_inc(input logic [F_W-1:0] f);
        return (f == F_LAST) ? '0 : f + 2'h1;
    endfunction

    logic             take;
    logic             stall;
    logic [CNT_W-1:0] width;
    logic [3:0]       gw;
    logic [SIG_W-1:0] smask;
    logic [F_W-1:0]   f_in;
    logic [SIG_W-1:0] total;
    logic             b;

    assign take  = cw_valid && st_reg.rdy;
    assign stall = st_reg.pend && !push_if.ready;
    assign width = chr_width(st_reg.sec, st_reg.blk);
    assign gw    = st_reg.sec ? SEC_GRP_BITS : HEX_GRP_BITS;
    assign smask = st_reg.sec ? SEC_SIG_MASK : HEX_SIG_MASK;
    assign f_in  = mode_secure ? cw_data[SEC_F_LSB +: F_W] : cw_data[HEX_F_LSB +: F_W];
    // a trailing part group is counted with its missing high bits as zero
    assign total = st_reg.sum + st_reg.grp;
    assign b     = st_reg.cw[st_reg.bitpos];

    always_comb
    begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        if (st_reg.pend && push_if.ready)
            st_next.pend = 1'b0;
        case (st_reg.phase)
            HSMFP_IDLE:
            begin
                if (take)
                begin
                    st_next.cw   = cw_data;
                    st_next.last = cw_last;
                    // only the final codeword of a fragment carries fill
                    st_next.lim  = cw_last ? fill_limit(cw_data) : CW_BITS; // [RULE3] [RULE4] [RULE19]
                    if (cw_first)
                    begin
                        st_next.sec  = mode_secure;
                        st_next.widx = W_SECOND;
                        st_next.cont = mode_secure ? cw_data[SEC_C_POS] : cw_data[HEX_C_POS]; // [RULE5] [RULE7]
                        st_next.frag = f_in;
                        st_next.num  = mode_secure ? cw_data[SEC_N_LSB +: N_W] : cw_data[HEX_N_LSB +: N_W];
                        st_next.cksum = mode_secure ? {2'h0, cw_data[SEC_K_W-1:0]}
                                                    : cw_data[HEX_K_W-1:0]; // [RULE6] [RULE20]
                        if (!st_reg.cont)
                        begin
                            st_next.first_frag = 1'b1;
                            st_next.seq_err    = 1'b0;
                            st_next.mism       = 1'b0;
                            st_next.sum        = '0;
                            st_next.grp        = '0;
                            st_next.gcnt       = '0;
                            st_next.acnt       = '0;
                        end
                        else
                        begin
                            st_next.first_frag = 1'b0;
                            if (f_in != frag_inc(st_reg.frag))
                                st_next.seq_err = 1'b1; // [RULE8]
                        end
                    end
                    else if (st_reg.widx == W_SECOND && st_reg.first_frag)
                    begin
                        st_next.widx = W_DATA;
                        if (st_reg.sec)
                        begin
                            // secure control word: signature then characters
                            st_next.sig    = {1'b0, cw_data[SEC_S_LSB +: SEC_SIG_W]};
                            st_next.phase  = HSMFP_SHIFT;
                            st_next.bitpos = SEC_DATA_LSB; // [RULE18] [RULE17]
                        end
                        else
                        begin
                            st_next.retr  = cw_data[R_POS]; // [RULE10] [RULE11]
                            st_next.mail  = cw_data[M_POS]; // [RULE13]
                            st_next.hdr   = cw_data[H_POS]; // [RULE9]
                            st_next.blk   = cw_data[B_LSB +: B_W]; // [RULE15]
                            st_next.cmode = cw_data[B_LSB +: B_W] != B_TRANSPARENT;
                            st_next.dir   = cw_data[D_POS] && (cw_data[B_LSB +: B_W] != B_TRANSPARENT); // [RULE14]
                            // reserved bits RSV_LSB..+RSV_W are not stored; the top one, at HEX_C_POS, gates done when this word is last [RULE12]
                            st_next.sig   = cw_data[HEX_S_LSB +: SIG_W];
                            if (cw_last)
                            begin
                                st_next.done = !cw_data[HEX_C_POS] && !st_reg.cont;
                                st_next.mism = ~total != cw_data[HEX_S_LSB +: SIG_W];
                            end
                        end
                    end
                    else
                    begin
                        st_next.widx   = W_DATA;
                        st_next.phase  = HSMFP_SHIFT;
                        st_next.bitpos = '0;
                    end
                end
            end
            HSMFP_SHIFT:
            begin
                if (stall)
                begin
                    // hold everything until the buffer takes the pending character
                end
                else if (st_reg.bitpos >= st_reg.lim || st_reg.bitpos >= CW_BITS)
                begin
                    st_next.phase = HSMFP_IDLE;
                    if (st_reg.last)
                    begin
                        st_next.acnt = '0; // [RULE2]
                        st_next.acc  = '0;
                        if (!st_reg.cont)
                        begin
                            st_next.done = 1'b1; // [RULE21]
                            st_next.mism = ((~total) & smask) != (st_reg.sig & smask); // [RULE16] [RULE21]
                        end
                    end
                end
                else
                begin
                    st_next.bitpos = st_reg.bitpos + 5'h01;
                    // earlier bits land in lower positions of both character and group
                    st_next.acc[st_reg.acnt[3:0]] = b; // [RULE1]
                    if (st_reg.acnt + 5'h01 == width)
                    begin
                        st_next.pend = 1'b1;
                        st_next.chr  = st_next.acc;
                        st_next.acc  = '0;
                        st_next.acnt = '0;
                    end
                    else
                        st_next.acnt = st_reg.acnt + 5'h01;
                    st_next.grp[st_reg.gcnt[2:0]] = b; // [RULE17]
                    if (st_reg.gcnt + 4'h1 == gw)
                    begin
                        st_next.sum  = st_reg.sum + st_next.grp; // [RULE16]
                        st_next.grp  = '0;
                        st_next.gcnt = '0;
                    end
                    else
                        st_next.gcnt = st_reg.gcnt + 4'h1;
                end
            end
            default:
                st_next.phase = HSMFP_IDLE;
        endcase
        st_next.rdy = (st_next.phase == HSMFP_IDLE) && !(take && !cw_first && st_reg.widx != W_SECOND);
        // registered copy of the width so the port leaves a flop
        st_next.cbits = chr_width(st_next.sec, st_next.blk); // [RULE15]
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_reg     <= '0;
            st_reg.rdy <= 1'b1;
            st_reg.blk <= B_TRANSPARENT;
            st_reg.cbits <= {1'b0, B_TRANSPARENT};
        end
        else
            st_reg <= st_next;
    end

    assign push_if.valid = st_reg.pend;
    assign push_if.data  = st_reg.chr;
    assign out_if.ready  = chr_ready;

    hsmfp_buffer u_buffer (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .push    (push_if),
        .pop     (out_if)
    );

    assign cw_ready     = st_reg.rdy;
    assign chr_valid    = out_if.valid;
    assign chr_data     = out_if.data;
    assign frag_cksum   = st_reg.cksum;
    assign expect_more  = st_reg.cont;
    assign frag_num     = st_reg.frag;
    assign msg_num      = st_reg.num;
    assign hdr_msg      = st_reg.hdr;
    assign retrieve_num = st_reg.retr;
    assign mail_drop    = st_reg.mail;
    assign dir_rtl      = st_reg.dir;
    assign char_mode    = st_reg.cmode;
    assign chr_bits     = st_reg.cbits;
    assign sig_rx       = st_reg.sig;
    assign msg_done     = st_reg.done;
    assign sig_mismatch = st_reg.mism;
    assign frag_seq_err = st_reg.seq_err;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    a_fill_boundary: assert property (take && !cw_first && cw_last && st_reg.widx == W_DATA |=> // [RULE3]
        st_reg.lim == '0 || st_reg.cw[st_reg.lim - 5'h01] != st_reg.cw[CW_W-1])
        else $error("data limit not at fill inversion");
    a_fill_marker: assert property (take && !cw_first && cw_last && (cw_data == '0 || cw_data == '1) |=> // [RULE4]
        st_reg.lim == '0)
        else $error("all-fill codeword produced data");
    a_char_width: assert property (st_reg.acnt < width) // [RULE1]
        else $error("character count exceeds width");
    a_partial_drop: assert property (st_reg.phase == HSMFP_SHIFT && st_reg.last && !stall && // [RULE2]
        st_reg.bitpos >= st_reg.lim |=> st_reg.acnt == '0 && st_reg.phase == HSMFP_IDLE)
        else $error("partial character kept at fragment end");
    a_seq_check: assert property (take && cw_first && st_reg.cont && f_in != frag_inc(st_reg.frag) // [RULE8]
        |=> frag_seq_err [*2])
        else $error("fragment sequence error not flagged");
    a_cont_flag: assert property (take && cw_first && !mode_secure |=> // [RULE7]
        expect_more == $past(cw_data[HEX_C_POS]) && frag_cksum == $past(cw_data[HEX_K_W-1:0]))
        else $error("continuation or checksum not captured");
    a_done_final: assert property (msg_done |-> !expect_more ##1 !msg_done) // [RULE21]
        else $error("done not a single pulse after final fragment");
    a_sec_width: assert property (st_reg.pend && st_reg.sec |-> (st_reg.chr >> SEC_CHR_BITS) == '0) // [RULE18]
        else $error("secure character wider than seven bits");
    a_stall_hold: assert property (stall && st_reg.phase == HSMFP_SHIFT |=> // [RULE1]
        st_reg.bitpos == $past(st_reg.bitpos) && st_reg.pend)
        else $error("shift advanced while character pending");

    c_msg_done: cover property (msg_done);
    c_mismatch: cover property (msg_done && sig_mismatch);
    c_seq_err:  cover property ($rose(frag_seq_err));
    c_stall:    cover property (stall && st_reg.phase == HSMFP_SHIFT);
endmodule

// ==== hsmfp_cw_source.sv ====
// codeword source standing in for the radio receiver side of the parser
`timescale 1ns/1ps
module hsmfp_cw_source (
    input  wire logic         sys_clk,
    input  wire logic         cw_ready,
    output logic              mode_secure,
    output logic              cw_valid,
    output logic [20:0]       cw_data,
    output logic              cw_first,
    output logic              cw_last
);
    initial
    begin
        mode_secure = 1'b0;
        cw_valid    = 1'b0;
        cw_data     = 21'h000000;
        cw_first    = 1'b0;
        cw_last     = 1'b0;
    end

    // offer one codeword and hold it until taken; released data is inverted so stale bits never look valid
    task automatic put(input logic sec, input logic [20:0] w, input logic f, input logic l);
        @(posedge sys_clk);
        mode_secure <= sec;
        cw_valid    <= 1'b1;
        cw_data     <= w;
        cw_first    <= f;
        cw_last     <= l;
        do
            @(negedge sys_clk);
        while (cw_ready !== 1'b1);
        @(posedge sys_clk);
        cw_valid    <= 1'b0;
        cw_data     <= ~w;
    endtask
endmodule

// ==== tb_hex_secure_message_field_parser.sv ====
// self-checking bench for the hex and secure message field parser
`timescale 1ns/1ps
module tb_hex_secure_message_field_parser;
    import hsmfp_pkg::*;
    logic              sys_clk, rst_b, chr_ready, cw_ready, chr_valid;
    logic              mode_secure, cw_valid, cw_first, cw_last;
    logic [CW_W-1:0]   cw_data;
    logic [CHR_W-1:0]  chr_data;
    logic [HEX_K_W-1:0] frag_cksum;
    logic [F_W-1:0]    frag_num;
    logic [N_W-1:0]    msg_num;
    logic [CNT_W-1:0]  chr_bits;
    logic [SIG_W-1:0]  sig_rx;
    logic              expect_more, hdr_msg, retrieve_num, mail_drop, dir_rtl, char_mode;
    logic              msg_done, sig_mismatch, frag_seq_err, mis_at_done;
    logic [15:0]       got_q[$];
    int                failures = 0, num_checks = 0, done_cnt = 0;

    hsmfp_cw_source src_u (.sys_clk(sys_clk), .cw_ready(cw_ready), .mode_secure(mode_secure),
        .cw_valid(cw_valid), .cw_data(cw_data), .cw_first(cw_first), .cw_last(cw_last));
    hsmfp_parser dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .mode_secure(mode_secure), .cw_valid(cw_valid),
        .cw_data(cw_data), .cw_first(cw_first), .cw_last(cw_last), .cw_ready(cw_ready),
        .chr_valid(chr_valid), .chr_data(chr_data), .chr_ready(chr_ready), .frag_cksum(frag_cksum),
        .expect_more(expect_more), .frag_num(frag_num), .msg_num(msg_num), .hdr_msg(hdr_msg),
        .retrieve_num(retrieve_num), .mail_drop(mail_drop), .dir_rtl(dir_rtl), .char_mode(char_mode),
        .chr_bits(chr_bits), .sig_rx(sig_rx), .msg_done(msg_done), .sig_mismatch(sig_mismatch),
        .frag_seq_err(frag_seq_err));

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        if (chr_valid === 1'b1 && chr_ready === 1'b1)
            got_q.push_back(chr_data);
        if (msg_done === 1'b1)
        begin
            done_cnt++;
            mis_at_done = sig_mismatch;
        end
    end

    function automatic logic [20:0] hx1(logic [11:0] k, logic c, logic [1:0] f, logic [5:0] n);
        return {n, f, c, k};
    endfunction
    function automatic logic [20:0] hx2(logic r, logic m, logic d, logic h, logic [3:0] b, logic [7:0] s);
        return {s, 5'h00, b, h, d, m, r};
    endfunction

    task automatic chk(input string nm, input logic [20:0] e, input logic [20:0] g);
        num_checks++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_chars(input logic [15:0] e[$]);
        chk("char count", 21'(e.size()), 21'(got_q.size()));
        foreach (e[i])
            if (i < got_q.size())
                chk("char", 21'(e[i]), 21'(got_q[i]));
        got_q.delete();
    endtask
    // bounded wait for the end pulse, then settle to mid-cycle for field checks
    task automatic wait_done(input int n);
        int k;
        k = 0;
        while (done_cnt < n && k < 400)
        begin
            @(posedge sys_clk);
            k++;
        end
        @(negedge sys_clk);
        chk("end pulses", 21'(n), 21'(done_cnt));
    endtask

    task automatic s_reset_vals();
        @(negedge sys_clk);
        chk("ready in reset", 21'h1, 21'(cw_ready));
        chk("width in reset", 21'h1, 21'(chr_bits));
        chk("valid in reset", 21'h0, 21'({chr_valid, msg_done, sig_mismatch, frag_seq_err}));
    endtask

    // 4-bit characters, receiver stalled while the buffer fills
    task automatic s_hex_single();
        done_cnt = 0;
        @(posedge sys_clk);
        chr_ready <= 1'b0;
        src_u.put(1'b0, hx1(12'hA5C, 1'b0, 2'h0, 6'h2A), 1'b1, 1'b0);
        src_u.put(1'b0, hx2(1'b1, 1'b0, 1'b1, 1'b1, 4'h4, 8'h92), 1'b0, 1'b0);
        src_u.put(1'b0, 21'h094321, 1'b0, 1'b1);
        repeat (40) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("chars during stall", 21'h0, 21'(got_q.size()));
        chk("valid during stall", 21'h1, 21'(chr_valid));
        @(posedge sys_clk);
        chr_ready <= 1'b1;
        wait_done(1);
        chk_chars({16'h1, 16'h2, 16'h3, 16'h4, 16'h9});
        chk("checksum", 21'hA5C, 21'(frag_cksum));
        chk("msg number", 21'h2A, 21'(msg_num));
        chk("flags", 21'h1B, 21'({hdr_msg, retrieve_num, mail_drop, dir_rtl, char_mode}));
        chk("width", 21'h4, 21'(chr_bits));
        chk("signature", 21'h92, 21'(sig_rx));
        chk("mismatch", 21'h0, 21'(mis_at_done));
        chk("more", 21'h0, 21'(expect_more));
    endtask

    // 16-bit characters over two fragments, wrong signature
    task automatic s_hex_two_frag();
        done_cnt = 0;
        src_u.put(1'b0, hx1(12'h123, 1'b1, 2'h0, 6'h05), 1'b1, 1'b0);
        src_u.put(1'b0, hx2(1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 8'h7C), 1'b0, 1'b0);
        src_u.put(1'b0, 21'h008001, 1'b0, 1'b1);
        repeat (30) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("more after part", 21'h1, 21'(expect_more));
        chk("no end yet", 21'h0, 21'(done_cnt));
        src_u.put(1'b0, hx1(12'h456, 1'b0, 2'h1, 6'h05), 1'b1, 1'b0);
        src_u.put(1'b0, 21'h1F0003, 1'b0, 1'b1);
        wait_done(1);
        chk_chars({16'h8001, 16'h0003});
        chk("flags 2", 21'h03, 21'({hdr_msg, retrieve_num, mail_drop, dir_rtl, char_mode}));
        chk("width 16", 21'h10, 21'(chr_bits));
        chk("fragment", 21'h1, 21'(frag_num));
        chk("checksum 2", 21'h456, 21'(frag_cksum));
        chk("seq ok", 21'h0, 21'(frag_seq_err));
        chk("mismatch set", 21'h1, 21'(mis_at_done));
        chk("sig kept", 21'h7C, 21'(sig_rx));
    endtask

    // transparent data, fragment number skips a step
    task automatic s_seq_err();
        src_u.put(1'b0, hx1(12'h001, 1'b1, 2'h0, 6'h07), 1'b1, 1'b0);
        src_u.put(1'b0, hx2(1'b0, 1'b0, 1'b1, 1'b0, 4'h1, 8'h00), 1'b0, 1'b0);
        src_u.put(1'b0, 21'h000001, 1'b0, 1'b1);
        src_u.put(1'b0, hx1(12'h002, 1'b0, 2'h2, 6'h07), 1'b1, 1'b0);
        src_u.put(1'b0, 21'h1FFFFE, 1'b0, 1'b1);
        repeat (30) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("seq error", 21'h1, 21'(frag_seq_err));
        chk("plain bits", 21'h0, 21'({dir_rtl, char_mode}));
        chk("width 1", 21'h1, 21'(chr_bits));
        chk_chars({16'h1, 16'h0});
    endtask

    // 7-bit characters, last word exactly full so an all-fill word follows
    task automatic s_secure();
        done_cnt = 0;
        src_u.put(1'b1, {2'h0, 6'h11, 2'h0, 1'b0, 10'h3FF}, 1'b1, 1'b0);
        src_u.put(1'b1, {7'h42, 7'h41, 7'h30}, 1'b0, 1'b0);
        src_u.put(1'b1, {7'h45, 7'h44, 7'h43}, 1'b0, 1'b0);
        src_u.put(1'b1, 21'h000000, 1'b0, 1'b1);
        wait_done(1);
        chk_chars({16'h41, 16'h42, 16'h43, 16'h44, 16'h45});
        chk("sec checksum", 21'h3FF, 21'(frag_cksum));
        chk("sec number", 21'h11, 21'(msg_num));
        chk("sec width", 21'h7, 21'(chr_bits));
        chk("sec signature", 21'h30, 21'(sig_rx));
        chk("sec mismatch", 21'h0, 21'(mis_at_done));
    endtask

    task automatic stop_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // the whole run needs well under a thousand cycles
    initial
    begin
        repeat (6000) @(posedge sys_clk);
        failures++;
        stop_test();
    end

    initial
    begin
        rst_b = 1'b0;
        chr_ready = 1'b1;
        repeat (5) @(posedge sys_clk);
        s_reset_vals();
        @(posedge sys_clk);
        rst_b <= 1'b1;
        s_hex_single();
        s_hex_two_frag();
        s_seq_err();
        s_secure();
        stop_test();
    end
endmodule
